// ---- common/dswl_pkg.sv ----
// Package: constants and types for the serial write / latch control block
package dswl_pkg;
  localparam int          WORD_BITS      = 16;
  localparam int          CODE_BITS      = 12;
  localparam int          CNT_BITS       = 5;
  localparam int          IGNORE_POS     = 15;
  localparam int          DONTCARE_POS   = 14;
  localparam int          GAIN_POS       = 13;
  localparam int          RUN_POS        = 12;
  localparam int          CODE_MSB       = 11;
  localparam logic        GAIN_RST       = 1'h0;
  localparam logic        RUN_RST        = 1'h0;
  localparam logic [11:0] CODE_RST       = 12'h000;
  localparam logic [15:0] WORD_RST       = 16'h0000;
  localparam int          CLK_HZ         = 25000000;
  localparam int          SETTLE_NS      = 4500;
  localparam int          WAKE_SETTLE_NS = 10000;
  localparam int          SETTLE_CYC     = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int          WAKE_CYC       = (WAKE_SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;

  typedef enum logic [2:0] {
    DSWL_IDLE  = 3'h1,
    DSWL_SHIFT = 3'h2,
    DSWL_FULL  = 3'h4
  } dswl_state_t;
endpackage : dswl_pkg

// ---- common/dswl_word_if.sv ----
// Interface: carries a received word and its commit pulse between modules
`timescale 1ns/10ps
interface dswl_word_if;
  logic [15:0] word;
  logic        commit;
  modport src (output word, output commit);
  modport dst (input word, input commit);
endinterface : dswl_word_if

// ---- logic/dswl_sync.sv ----
// Module: two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module dswl_sync #(
  parameter int         WIDTH = 1,
  parameter logic [0:0] RST   = 1'h0
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) $error("dswl_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= {WIDTH{RST}};
      q      <= {WIDTH{RST}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : dswl_sync

// ---- logic/dswl_shift.sv ----
// Module: serial frame receiver, counts clocks and commits complete words
`timescale 1ns/10ps
module dswl_shift (
  input  wire logic   clk,
  input  wire logic   rstn,
  input  wire logic   cs_n_s,
  input  wire logic   sck_s,
  input  wire logic   sdi_s,
  dswl_word_if.src    wr
);
  dswl_pkg::dswl_state_t state_q;
  logic                         sck_prev_q;
  logic [dswl_pkg::CNT_BITS-1:0] cnt_q;
  logic [15:0]                  sh_q;
  logic                         commit_q;
  logic                         rise;

  assign rise      = sck_s & ~sck_prev_q;
  assign wr.word   = sh_q;
  assign wr.commit = commit_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_prev_q <= 1'h0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q  <= dswl_pkg::DSWL_IDLE;
      cnt_q    <= '0;
      sh_q     <= dswl_pkg::WORD_RST;
      commit_q <= 1'h0;
    end else begin
      commit_q <= 1'h0;
      case (state_q)
        dswl_pkg::DSWL_IDLE: begin
          cnt_q <= '0;
          // Clock edges with select high are ignored entirely
          if (!cs_n_s) begin
            state_q <= dswl_pkg::DSWL_SHIFT;
          end
        end
        dswl_pkg::DSWL_SHIFT: begin
          if (cs_n_s) begin
            state_q <= dswl_pkg::DSWL_IDLE;
          end else if (rise) begin
            sh_q  <= {sh_q[14:0], sdi_s};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'(dswl_pkg::WORD_BITS - 1)) begin
              state_q <= dswl_pkg::DSWL_FULL;
            end
          end
        end
        dswl_pkg::DSWL_FULL: begin
          // Further clocks leave the word alone
          if (cs_n_s) begin
            state_q  <= dswl_pkg::DSWL_IDLE;
            commit_q <= 1'h1;
          end
        end
        default: begin
          state_q <= dswl_pkg::DSWL_IDLE;
        end
      endcase
    end
  end
endmodule : dswl_shift

// ---- logic/dswl_top.sv ----
// Module: top of the DAC serial write and latch control logic
//
// Behaviour
// - Data sampled on serial clock rising edges, modes 0,0 and 1,1.
// - Link is write-only; no data output exists.
// - Sixteen-bit word, MSB first: four config bits then twelve data bits.
// - Select rising after full word captures it into input register.
// - Clock edges past the sixteenth are ignored.
// - Select rising early aborts; input register keeps old contents.
// - With select high, no shifting and clock/data ignored.
// - Load strobe low copies input register into output register.
// - Strobe tied low: output updates right after valid frame ends.
// - Bit 15 set discards write; bit 14 is don't care.
// - Bit 13: one is unity gain, zero is double gain.
// - Bit 12: one active, zero shutdown; resets to zero.
// - Code is left-justified; narrow variants drop low bits.
// - Output stays shut down after power-on until valid write loaded.
// - After reset release, reset state holds until a new write.
// - Shutdown when bit is zero or pin low; interface keeps working.
// - Leave shutdown when active bit latched and pin high.
// - Default gain is double.
`timescale 1ns/10ps
module dswl_top #(
  parameter int RES_BITS = 12
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic        sdi,
  input  wire logic        output_load_strobe_n,
  input  wire logic        power_down_n,
  output logic             gain_select_n,
  output logic             output_active,
  output logic [11:0]      dac_code,
  output logic             output_valid,
  output logic             settling
);
  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  initial begin
    if (RES_BITS != 8 && RES_BITS != 10 && RES_BITS != 12) begin
      $error("dswl_top: RES_BITS must be 8, 10 or 12");
    end
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic cs_n_s;
  logic sck_s;
  logic sdi_s;
  logic ld_n_s;
  logic pd_n_s;

  dswl_sync #(.WIDTH(1), .RST(1'h1)) u_sync_cs (
    .clk  (clk),
    .rstn (rstn),
    .d    (cs_n),
    .q    (cs_n_s)
  );
  dswl_sync #(.WIDTH(2), .RST(1'h0)) u_sync_data (
    .clk  (clk),
    .rstn (rstn),
    .d    ({sck, sdi}),
    .q    ({sck_s, sdi_s})
  );
  dswl_sync #(.WIDTH(1), .RST(1'h1)) u_sync_ld (
    .clk  (clk),
    .rstn (rstn),
    .d    (output_load_strobe_n),
    .q    (ld_n_s)
  );
  dswl_sync #(.WIDTH(1), .RST(1'h1)) u_sync_pd (
    .clk  (clk),
    .rstn (rstn),
    .d    (power_down_n),
    .q    (pd_n_s)
  );

  // ----------------------------------------------------------------------
  // Serial receiver
  // ----------------------------------------------------------------------
  dswl_word_if wr ();

  // The receiver has no output towards the host at all
  dswl_shift u_shift (
    .clk    (clk),
    .rstn   (rstn),
    .cs_n_s (cs_n_s),
    .sck_s  (sck_s),
    .sdi_s  (sdi_s),
    .wr     (wr)
  );

  // ----------------------------------------------------------------------
  // Input register
  // ----------------------------------------------------------------------
  function automatic logic [11:0] dswl_mask_code(input logic [11:0] raw);
    logic [11:0] m;
    m = raw;
    if (RES_BITS == 10) begin
      m[1:0] = 2'h0;
    end else if (RES_BITS == 8) begin
      m[3:0] = 4'h0;
    end
    return m;
  endfunction

  logic        in_gain_q;
  logic        in_run_q;
  logic [11:0] in_code_q;
  logic        in_valid_q;
  logic        accept;

  // Only words with a clear top bit count; bit 14 is never looked at
  assign accept = wr.commit & ~wr.word[dswl_pkg::IGNORE_POS];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_gain_q  <= dswl_pkg::GAIN_RST;
      in_run_q   <= dswl_pkg::RUN_RST;
      in_code_q  <= dswl_pkg::CODE_RST;
      in_valid_q <= 1'h0;
    end else if (accept) begin
      in_gain_q  <= wr.word[dswl_pkg::GAIN_POS];
      in_run_q   <= wr.word[dswl_pkg::RUN_POS];
      in_code_q  <= dswl_mask_code(wr.word[dswl_pkg::CODE_MSB:0]);
      in_valid_q <= 1'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------------
  logic        out_gain_q;
  logic        out_run_q;
  logic [11:0] out_code_q;
  logic        out_valid_q;

  // Level-sensitive transfer: a strobe held low tracks each new accepted word
  // one cycle after it lands in the input register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_gain_q  <= dswl_pkg::GAIN_RST;
      out_run_q   <= dswl_pkg::RUN_RST;
      out_code_q  <= dswl_pkg::CODE_RST;
      out_valid_q <= 1'h0;
    end else if (!ld_n_s && in_valid_q) begin
      out_gain_q  <= in_gain_q;
      out_run_q   <= in_run_q;
      out_code_q  <= in_code_q;
      out_valid_q <= 1'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Shutdown and output drive
  // ----------------------------------------------------------------------
  logic active_d;

  // Pin or register bit each force shutdown; receiver runs regardless
  assign active_d = out_valid_q & out_run_q & pd_n_s;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      output_active <= 1'h0;
      gain_select_n <= dswl_pkg::GAIN_RST;
      dac_code      <= dswl_pkg::CODE_RST;
      output_valid  <= 1'h0;
    end else begin
      output_active <= active_d;
      gain_select_n <= out_gain_q;
      dac_code      <= out_code_q;
      output_valid  <= out_valid_q;
    end
  end

  // ----------------------------------------------------------------------
  // Settling indicator
  // ----------------------------------------------------------------------
  // Marks the window the host must wait; longer after a wake from shutdown
  localparam int SET_W = 10;
  logic [SET_W-1:0] settle_q;
  logic             active_q;
  logic             out_change;

  assign out_change = (!ld_n_s && in_valid_q) &&
                      (in_code_q != out_code_q || in_gain_q != out_gain_q);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      settle_q <= '0;
      active_q <= 1'h0;
      settling <= 1'h0;
    end else begin
      active_q <= active_d;
      if (active_d && !active_q) begin
        settle_q <= SET_W'(dswl_pkg::WAKE_CYC);
      end else if (out_change && active_d && settle_q < SET_W'(dswl_pkg::SETTLE_CYC)) begin
        settle_q <= SET_W'(dswl_pkg::SETTLE_CYC);
      end else if (settle_q != '0) begin
        settle_q <= settle_q - 1'b1;
      end
      settling <= (settle_q > 1) || (active_d && !active_q);
    end
  end
endmodule : dswl_top

// ---- sim/dswl_props.sv ----
// Checker: port-level properties of the DAC write and latch control
`timescale 1ns/10ps
module dswl_props #(
  parameter int RES_BITS = 12
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        cs_n,
  input wire logic        sck,
  input wire logic        sdi,
  input wire logic        output_load_strobe_n,
  input wire logic        power_down_n,
  input wire logic        gain_select_n,
  input wire logic        output_active,
  input wire logic [11:0] dac_code,
  input wire logic        output_valid,
  input wire logic        settling
);
  localparam logic [11:0] LOW_MASK = 12'hfff >> RES_BITS;
  logic [2:0] quiet_q;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Seven cycles of strobe high outlast the pin sync, so no load can be in flight
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) quiet_q <= 3'h0;
    else if (!output_load_strobe_n) quiet_q <= 3'h0;
    else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
  end
  sequence s_pin_low;
    !power_down_n [*4];
  endsequence
  sequence s_no_word;
    !output_valid;
  endsequence
  a_pin_forces_off: assert property (s_pin_low |-> !output_active) else $error("active with pin low");
  // The pin reaches the output through two sync flops and the output flop
  a_wake_needs_pin: assert property ($rose(output_active) |-> $past(power_down_n, 3))
    else $error("woke with pin low");
  a_reset_state_held: assert property (s_no_word |->
    !gain_select_n && !output_active && dac_code == 12'h000) else $error("outputs moved before a word");
  a_active_needs_word: assert property (output_active |-> output_valid)
    else $error("active without word");
  a_valid_stays_set: assert property (output_valid |=> output_valid) else $error("valid dropped");
  a_low_bits_zero: assert property ((dac_code & LOW_MASK) == 12'h000) else $error("low code bits set");
  a_quiet_hold_out: assert property (quiet_q == 3'h7 |-> $stable(dac_code) && $stable(gain_select_n))
    else $error("output changed with strobe high");
  a_gain_needs_word: assert property ($changed(gain_select_n) |-> output_valid)
    else $error("gain moved early");
endmodule : dswl_props

bind dswl_top dswl_props #(.RES_BITS(RES_BITS)) u_props (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .sdi(sdi),
  .output_load_strobe_n(output_load_strobe_n), .power_down_n(power_down_n), .gain_select_n(gain_select_n),
  .output_active(output_active), .dac_code(dac_code), .output_valid(output_valid), .settling(settling));

// ---- sim/dswl_host.sv ----
// Partner model: host serial master driving the write link
`timescale 1ns/10ps
module dswl_host (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sck,
  output logic      sdi
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    sdi  = 1'b0;
  end
  // Half of the 320 ns link period
  task automatic half();
    repeat (4) @(negedge clk);
  endtask
  // Mode 1,1 idles the clock high; bits past the sixteenth go out as ones
  task automatic send(input logic [15:0] w, input int n, input bit m11);
    // Idle clock level settles before select falls, so no edge straddles it
    sck  = m11;
    half();
    cs_n = 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      sck = 1'b0;
      sdi = (i < 16) ? w[15 - i] : 1'b1;
      half();
      sck = 1'b1;
      half();
    end
    sck = m11;
    half();
    cs_n = 1'b1;
    sdi  = ~sdi;
  endtask
endmodule : dswl_host

// ---- sim/dswl_top_tb.sv ----
// Testbench: self-checking run of the DAC write and latch control
`timescale 1ns/10ps
module dswl_top_tb;
  logic        clk;
  logic        rstn;
  logic        cs_n;
  logic        sck;
  logic        sdi;
  logic        strobe_n;
  logic        pin_n;
  logic        gain_select_n;
  logic        output_active;
  logic [11:0] dac_code;
  logic        output_valid;
  logic        settling;
  logic [11:0] code8;
  int          errors;
  int          check_count;

  dswl_top #(.RES_BITS(12)) u_dut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .sdi(sdi),
    .output_load_strobe_n(strobe_n), .power_down_n(pin_n), .gain_select_n(gain_select_n),
    .output_active(output_active), .dac_code(dac_code), .output_valid(output_valid), .settling(settling));
  // Narrow variant on the same link and pins; only its code is compared
  dswl_top #(.RES_BITS(8)) u_dut8 (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .sdi(sdi),
    .output_load_strobe_n(strobe_n), .power_down_n(pin_n), .gain_select_n(), .output_active(), .dac_code(code8),
    .output_valid(), .settling());
  dswl_host u_host (.clk(clk), .cs_n(cs_n), .sck(sck), .sdi(sdi));

  always #20 clk = ~clk;

  task automatic chk(input logic [14:0] seen, input logic [14:0] want);
    check_count++;
    if (seen !== want) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  // Packs {gain_n, active, valid, code}
  task automatic look(input logic [14:0] want);
    chk({gain_select_n, output_active, output_valid, dac_code}, want);
  endtask
  // Ten cycles cover the sync and latch path after select rises
  task automatic frame(input logic [15:0] w, input int n, input bit m11);
    u_host.send(w, n, m11);
    repeat (10) @(negedge clk);
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic t_load();
    look(15'h0000);
    frame(16'h3abc, 16, 1'b0);
    look(15'h0000);
    strobe_n = 1'b0;
    repeat (10) @(negedge clk);
    look(15'h7abc);
    chk({3'h0, code8}, 15'h0ab0);
    chk({14'h0000, settling}, 15'h0001);
    $display("test load done");
  endtask
  task automatic t_refuse();
    frame(16'hb123, 16, 1'b0);
    look(15'h7abc);
    frame(16'h3456, 15, 1'b0);
    look(15'h7abc);
    // The wake window has run out and refused words must not restart it
    chk({14'h0000, settling}, 15'h0000);
    frame(16'h4567, 20, 1'b1);
    look(15'h1567);
    $display("test refuse done");
  endtask
  task automatic t_shutdown();
    frame(16'h1fff, 16, 1'b0);
    look(15'h3fff);
    pin_n = 1'b0;
    repeat (10) @(negedge clk);
    look(15'h1fff);
    frame(16'h1aaa, 16, 1'b0);
    look(15'h1aaa);
    pin_n = 1'b1;
    repeat (10) @(negedge clk);
    look(15'h3aaa);
    chk({14'h0000, settling}, 15'h0001);
    $display("test shutdown done");
  endtask
  task automatic t_rereset();
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    look(15'h0000);
    frame(16'h2000, 16, 1'b0);
    look(15'h5000);
    // A word latched with the strobe high must wait in the input register
    strobe_n = 1'b1;
    frame(16'h3123, 16, 1'b0);
    look(15'h5000);
    strobe_n = 1'b0;
    repeat (10) @(negedge clk);
    look(15'h7123);
    $display("test rereset done");
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    strobe_n = 1'b1;
    pin_n = 1'b1;
    errors = 0;
    check_count = 0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_load();
    t_refuse();
    t_shutdown();
    t_rereset();
    final_report();
  end
  initial begin
    #2000000;
    errors++;
    final_report();
  end
endmodule : dswl_top_tb
